// [core/kpms_pkg.sv]
// package of constants and types for the keypad matrix scanner
package kpms_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h00;
   localparam logic [7:0] OFS_IRQ_SOURCE = 8'h04;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h08;
   localparam logic [7:0] OFS_CONTROL0   = 8'h0c;
   localparam logic [7:0] OFS_LINE_ENA   = 8'h10;
   localparam logic [7:0] OFS_DRIVE_PER  = 8'h14;
   localparam logic [7:0] OFS_STATE      = 8'h18;

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int LINES          = 4;
   localparam int KEYS           = 16;
   localparam int PERIOD_W       = 13;
   localparam int DRIVE_LSB      = 0;
   localparam int RETURN_LSB     = 4;
   localparam int CTL_VALUE_CLR  = 0;
   localparam int CTL_AUTO_CLR   = 1;
   localparam int CTL_SINGLE     = 3;
   localparam int CTL_POLARITY   = 4;
   localparam int CTL_ENABLE     = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [KEYS-1:0]     RST_MASK   = 16'hffff;
   localparam logic [PERIOD_W-1:0] RST_PERIOD = 13'h1fff;
   localparam logic [KEYS-1:0]     RST_KEYS   = 16'h0000;
   localparam logic [7:0]          RST_LINES  = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [31:0] kpms_word_t;
   typedef logic [1:0]  kpms_idx_t;

   typedef struct packed {
      logic enable;
      logic polarity;
      logic single_mode;
      logic auto_clr;
   } kpms_ctrl_s;

   typedef struct packed {
      logic [LINES-1:0] return_on;
      logic [LINES-1:0] drive_on;
   } kpms_lines_s;

   typedef struct packed {
      logic [LINES-1:0] out;
      logic [LINES-1:0] oe;
   } kpms_drive_s;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DRIVE = 2'b01
   } kpms_state_e;

endpackage

// [core/kpms_step_timer.sv]
// scan step timer: pulses once every limit+1 clocks while running
`timescale 1ns/1ps
module kpms_step_timer #(
   parameter int W = 13
) (
   input  wire logic         CLK,
   input  wire logic         SRST,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              tick
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge CLK) begin
      if (SRST || !run) begin
         cnt_q <= '0;
      end else if (cnt_q >= limit) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign tick = run && (cnt_q >= limit);
endmodule

// [core/kpms_top.sv]
// keypad matrix scanner with apb register port and key interrupt
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module kpms_top
   import kpms_pkg::*;
(
   input  wire logic                   CLK,
   input  wire logic                   SRST,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire kpms_pkg::kpms_word_t   PWDATA,
   output kpms_pkg::kpms_word_t        PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   output logic [kpms_pkg::LINES-1:0]  DRIVE_OUT,
   output logic [kpms_pkg::LINES-1:0]  DRIVE_OE,
   input  wire logic [kpms_pkg::LINES-1:0] RETURN_IN,
   output logic                        IRQ
);
   import kpms_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   kpms_ctrl_s           ctrl_q;
   kpms_lines_s          lines_q;
   logic [PERIOD_W-1:0]  period_q;
   logic [KEYS-1:0]      mask_q;
   logic [KEYS-1:0]      pending_q;
   logic [KEYS-1:0]      pending_d;
   logic [KEYS-1:0]      value_q;
   logic [KEYS-1:0]      value_d;
   kpms_state_e          state_q;
   kpms_state_e          state_d;
   kpms_idx_t            drive_idx_q;
   kpms_idx_t            drive_idx_d;
   kpms_drive_s          drive_q;
   kpms_drive_s          drive_d;
   logic                 tick;
   logic                 scan_run;
   logic [KEYS-1:0]      sample_bits;
   logic [KEYS-1:0]      sample_mask;
   logic                 ready_q;
   kpms_word_t           rdata_q;
   logic                 slverr_q;
   logic                 irq_q;
   logic                 access;
   logic                 done;
   logic                 wr_done;
   logic                 rd_done;
   logic                 mapped;
   logic                 writable;
   kpms_word_t           rdata_d;
   logic                 value_clr_req;

   // ----------------------------------------------------------------
   // apb transfer decode
   // ----------------------------------------------------------------
   assign access  = PSEL && PENABLE;
   assign done    = access && ready_q;
   assign wr_done = done && PWRITE && !slverr_q;
   assign rd_done = done && !PWRITE && !slverr_q;

   always_comb begin
      mapped   = 1'b1;
      writable = 1'b1;
      rdata_d  = '0;
      case (PADDR)
         OFS_IRQ_MASK: begin
            rdata_d[KEYS-1:0] = mask_q;
         end
         OFS_IRQ_SOURCE: begin
            rdata_d[KEYS-1:0] = pending_q & ~mask_q;
            writable          = 1'b0;
         end
         OFS_IRQ_CLEAR: begin
            rdata_d[KEYS-1:0] = pending_q;
         end
         OFS_CONTROL0: begin
            rdata_d[CTL_ENABLE]   = ctrl_q.enable;
            rdata_d[CTL_POLARITY] = ctrl_q.polarity;
            rdata_d[CTL_SINGLE]   = ctrl_q.single_mode;
            rdata_d[CTL_AUTO_CLR] = ctrl_q.auto_clr;
         end
         OFS_LINE_ENA: begin
            rdata_d[RETURN_LSB +: LINES] = lines_q.return_on;
            rdata_d[DRIVE_LSB  +: LINES] = lines_q.drive_on;
         end
         OFS_DRIVE_PER: begin
            rdata_d[PERIOD_W-1:0] = period_q;
         end
         OFS_STATE: begin
            rdata_d[KEYS-1:0] = value_q;
            writable          = 1'b0;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer: ready one cycle into the access phase
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ready_q  <= 1'b0;
         rdata_q  <= '0;
         slverr_q <= 1'b0;
      end else if (access && !ready_q) begin
         ready_q  <= 1'b1;
         rdata_q  <= PWRITE ? '0 : rdata_d;
         slverr_q <= !mapped || (PWRITE && !writable);
      end else begin
         ready_q  <= 1'b0;
         rdata_q  <= '0;
         slverr_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // software control registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl_q <= '0;
      end else if (wr_done && PADDR == OFS_CONTROL0) begin
         ctrl_q.enable      <= PWDATA[CTL_ENABLE];
         ctrl_q.polarity    <= PWDATA[CTL_POLARITY];
         ctrl_q.single_mode <= PWDATA[CTL_SINGLE];
         ctrl_q.auto_clr    <= PWDATA[CTL_AUTO_CLR];
      end
   end

   assign value_clr_req = wr_done && PADDR == OFS_CONTROL0 && PWDATA[CTL_VALUE_CLR];

   always_ff @(posedge CLK) begin
      if (SRST) begin
         lines_q <= RST_LINES;
      end else if (wr_done && PADDR == OFS_LINE_ENA) begin
         lines_q.drive_on  <= PWDATA[DRIVE_LSB  +: LINES];
         lines_q.return_on <= PWDATA[RETURN_LSB +: LINES];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         period_q <= RST_PERIOD;
      end else if (wr_done && PADDR == OFS_DRIVE_PER) begin
         period_q <= PWDATA[PERIOD_W-1:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         mask_q <= RST_MASK;
      end else if (wr_done && PADDR == OFS_IRQ_MASK) begin
         mask_q <= PWDATA[KEYS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // scan step timer
   // ----------------------------------------------------------------
   assign scan_run = ctrl_q.enable && (|lines_q.drive_on) && state_q == ST_DRIVE;

   kpms_step_timer #(
      .W (PERIOD_W)
   ) u_step (
      .CLK   (CLK),
      .SRST  (SRST),
      .run   (scan_run),
      .limit (period_q),
      .tick  (tick)
   );

   // ----------------------------------------------------------------
   // drive line sequencing
   // ----------------------------------------------------------------
   function automatic kpms_idx_t next_line(input kpms_idx_t cur,
                                           input logic [LINES-1:0] ena);
      kpms_idx_t cand;
      kpms_idx_t pick;
      pick = cur;
      for (int k = LINES - 1; k >= 1; k--) begin
         cand = cur + kpms_idx_t'(k);
         if (ena[cand]) begin
            pick = cand;
         end
      end
      return pick;
   endfunction

   function automatic kpms_idx_t first_line(input logic [LINES-1:0] ena);
      kpms_idx_t pick;
      pick = '0;
      for (int k = LINES - 1; k >= 0; k--) begin
         if (ena[k]) begin
            pick = kpms_idx_t'(k);
         end
      end
      return pick;
   endfunction

   always_comb begin
      state_d     = state_q;
      drive_idx_d = drive_idx_q;
      case (state_q)
         ST_IDLE: begin
            if (ctrl_q.enable && |lines_q.drive_on) begin
               state_d     = ST_DRIVE;
               drive_idx_d = first_line(lines_q.drive_on);
            end
         end
         ST_DRIVE: begin
            if (!ctrl_q.enable || !(|lines_q.drive_on)) begin
               state_d = ST_IDLE;
            end else if (!lines_q.drive_on[drive_idx_q]) begin
               drive_idx_d = next_line(drive_idx_q, lines_q.drive_on);
            end else if (tick) begin
               drive_idx_d = next_line(drive_idx_q, lines_q.drive_on);
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_q     <= ST_IDLE;
         drive_idx_q <= '0;
      end else begin
         state_q     <= state_d;
         drive_idx_q <= drive_idx_d;
      end
   end

   // ----------------------------------------------------------------
   // drive pins, registered from the next scan state
   // ----------------------------------------------------------------
   always_comb begin
      drive_d.oe  = '0;
      drive_d.out = '0;
      if (state_d == ST_DRIVE) begin
         drive_d.oe = lines_q.drive_on;
         for (int d = 0; d < LINES; d++) begin
            drive_d.out[d] = (d == int'(drive_idx_d)) ? ctrl_q.polarity
                                                      : !ctrl_q.polarity;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         drive_q <= '0;
      end else begin
         drive_q <= drive_d;
      end
   end

   // ----------------------------------------------------------------
   // return line sampling into the key vector
   // ----------------------------------------------------------------
   always_comb begin
      sample_bits = '0;
      sample_mask = '0;
      if (state_q == ST_DRIVE && tick && lines_q.drive_on[drive_idx_q]) begin
         for (int s = 0; s < LINES; s++) begin
            sample_mask[LINES * int'(drive_idx_q) + s] = 1'b1;
            sample_bits[LINES * int'(drive_idx_q) + s] =
               lines_q.return_on[s] && (RETURN_IN[s] == ctrl_q.polarity);
         end
      end
   end

   always_comb begin
      value_d = value_q;
      if (value_clr_req || (rd_done && PADDR == OFS_STATE && ctrl_q.auto_clr)) begin
         value_d = '0;
      end
      value_d = (value_d & ~sample_mask) | sample_bits;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         value_q <= RST_KEYS;
      end else begin
         value_q <= value_d;
      end
   end

   // ----------------------------------------------------------------
   // latched key events and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      pending_d = pending_q;
      if (wr_done && PADDR == OFS_IRQ_CLEAR) begin
         pending_d = pending_q & ~PWDATA[KEYS-1:0];
      end
      if (!ctrl_q.single_mode || pending_d == '0) begin
         pending_d = pending_d | sample_bits;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pending_q <= RST_KEYS;
         irq_q     <= 1'b0;
      end else begin
         pending_q <= pending_d;
         irq_q     <= |(pending_d & ~mask_q);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA    = rdata_q;
   assign PREADY    = ready_q;
   assign PSLVERR   = slverr_q;
   assign DRIVE_OUT = drive_q.out;
   assign DRIVE_OE  = drive_q.oe;
   assign IRQ       = irq_q;
endmodule

// [bench/kpms_chk.sv]
// port checks for the keypad matrix scanner, with its bind
`timescale 1ns/1ps
module kpms_chk (
   input wire logic                 CLK,
   input wire logic                 SRST,
   input wire logic                 PSEL,
   input wire logic                 PENABLE,
   input wire logic                 PWRITE,
   input wire logic [7:0]           PADDR,
   input wire kpms_pkg::kpms_word_t PWDATA,
   input wire kpms_pkg::kpms_word_t PRDATA,
   input wire logic                 PREADY,
   input wire logic                 PSLVERR,
   input wire logic [3:0]           DRIVE_OUT,
   input wire logic [3:0]           DRIVE_OE,
   input wire logic [3:0]           RETURN_IN,
   input wire logic                 IRQ
);
   import kpms_pkg::*;
   logic [3:0]  drv_q, ret_q, prev_q, act;
   logic [12:0] per_q;
   logic [13:0] run_q;
   logic        en_q, pol_q;
   wire         wr  = PSEL && PENABLE && PREADY && PWRITE;
   wire         chg = act != prev_q && act != 4'h0 && prev_q != 4'h0;
   assign act = (pol_q ? DRIVE_OUT : ~DRIVE_OUT) & DRIVE_OE;

   // shadow of the line enable, period, enable and polarity fields, taken at the completing edge
   always_ff @(posedge CLK) begin
      if (SRST) begin
         {ret_q, drv_q} <= RST_LINES;
         per_q <= RST_PERIOD;
         {en_q, pol_q} <= 2'b00;
      end else if (wr) begin
         if (PADDR == OFS_LINE_ENA) {ret_q, drv_q} <= PWDATA[7:0];
         if (PADDR == OFS_DRIVE_PER) per_q <= PWDATA[12:0];
         if (PADDR == OFS_CONTROL0) {en_q, pol_q} <= PWDATA[CTL_ENABLE:CTL_POLARITY];
      end
   end

   // length of the current step in clocks
   always_ff @(posedge CLK) begin
      if (SRST) begin
         prev_q <= 4'h0;
         run_q <= 14'h0;
      end else begin
         prev_q <= act;
         run_q <= (act != prev_q) ? 14'h1 : run_q + 14'h1;
      end
   end

   function automatic logic [3:0] nxt(logic [3:0] oh, logic [3:0] ena);
      logic [3:0] r;
      r = oh;
      for (int i = 0; i < 4; i++) begin
         r = {r[2:0], r[3]};
         if ((r & ena) != 4'h0) return r;
      end
      return oh;
   endfunction

   // --------
   // checks
   // --------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   chk_scan_gate: assert property (
      $past(en_q) == en_q |-> DRIVE_OE == (en_q ? drv_q : 4'h0)) else $error("drive enable");
   chk_idle_low: assert property (
      DRIVE_OE == 4'h0 |-> DRIVE_OUT == 4'h0) else $error("idle drive level");
   chk_one_active: assert property (
      DRIVE_OE != 4'h0 |-> $onehot(act)) else $error("active drive line");
   chk_step_len: assert property (
      chg |-> run_q == {1'b0, per_q} + 14'h1) else $error("step length");
   chk_step_next: assert property (
      chg |-> act == nxt(prev_q, drv_q)) else $error("step order");
   chk_apb_wait: assert property (
      PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY) else $error("bus wait");
   chk_ro_refused: assert property (
      wr && (PADDR == OFS_STATE || PADDR == OFS_IRQ_SOURCE) |-> PSLVERR) else $error("ro write");
   chk_value_width: assert property (
      PREADY && !PWRITE && PADDR == OFS_STATE |-> PRDATA[31:16] == 16'h0) else $error("vector");
   chk_line_read: assert property (
      PREADY && !PWRITE && PADDR == OFS_LINE_ENA |-> PRDATA == {24'h0, ret_q, drv_q})
      else $error("line enables");
   cover property (chg);
   cover property ($rose(IRQ));
   cover property (PSLVERR);
endmodule

bind kpms_top kpms_chk kpms_chk_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .DRIVE_OUT(DRIVE_OUT), .DRIVE_OE(DRIVE_OE), .RETURN_IN(RETURN_IN),
   .IRQ(IRQ));

// [bench/kpms_matrix.sv]
// passive key matrix with pull resistors on the return lines
`timescale 1ns/1ps
module kpms_matrix (
   input  wire logic [kpms_pkg::LINES-1:0] drive_out,
   input  wire logic [kpms_pkg::LINES-1:0] drive_oe,
   input  wire logic                       polarity,
   input  wire logic [kpms_pkg::KEYS-1:0]  keys,
   output logic      [kpms_pkg::LINES-1:0] return_in
);
   import kpms_pkg::*;
   always_comb begin
      for (int s = 0; s < LINES; s++) begin
         return_in[s] = ~polarity;
         for (int d = 0; d < LINES; d++) begin
            if (drive_oe[d] && drive_out[d] == polarity && keys[4 * d + s]) begin
               return_in[s] = polarity;
            end
         end
      end
   end
endmodule

// [bench/tb_keypad_matrix_scanner.sv]
// self-checking testbench for the keypad matrix scanner
`timescale 1ns/1ps
module tb_keypad_matrix_scanner;
   import kpms_pkg::*;
   logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, pol, ac, err, sm;
   logic [7:0]  PADDR, lin;
   logic [3:0]  DRIVE_OUT, DRIVE_OE, RETURN_IN;
   logic [15:0] keys, e1, e2, p, m, c;
   logic [12:0] per;
   kpms_word_t  PWDATA, PRDATA, rd, w;
   int          fails, tests_run;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   logic [15:0] rv [7] = '{16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1fff, 16'h0};
   logic [7:0]  wa [3] = '{OFS_IRQ_MASK, OFS_LINE_ENA, OFS_DRIVE_PER};
   logic [15:0] wm [3] = '{16'hffff, 16'h00ff, 16'h1fff};

   kpms_top kpms_top_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .DRIVE_OUT(DRIVE_OUT), .DRIVE_OE(DRIVE_OE), .RETURN_IN(RETURN_IN),
      .IRQ(IRQ));
   kpms_matrix kpms_matrix_i (.drive_out(DRIVE_OUT), .drive_oe(DRIVE_OE), .polarity(pol),
      .keys(keys), .return_in(RETURN_IN));

   // --------
   // tasks
   // --------
   task automatic check(string what, kpms_word_t seen, kpms_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one apb transfer; answer taken at the edge that sees pready high
   task automatic apb(logic wr, logic [7:0] a, kpms_word_t d);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge CLK);
         if (PREADY === 1'b1) break;
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n == 16) begin
         fails++;
         close_out();
      end
   endtask

   task automatic rchk(logic [7:0] a, kpms_word_t exp, string what);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask

   // keys seen only where both the drive and the return line are on
   function automatic logic [15:0] expv(logic [15:0] k, logic [7:0] l);
      for (int i = 0; i < 16; i++) expv[i] = k[i] & l[i / 4] & l[4 + i % 4];
   endfunction

   // single mode keeps only the first row with a key, in scan order
   function automatic logic [15:0] first_row(logic [15:0] v);
      first_row = 16'h0;
      for (int d = 3; d >= 0; d--) begin
         if (v[4 * d +: 4] != 4'h0) first_row = v & (16'h000f << (4 * d));
      end
   endfunction

   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   initial begin
      SRST = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h0;
      PWDATA = 32'h0;
      keys = 16'h0;
      pol = 1'b0;
      fails = 0;
      tests_run = 0;
      w = $urandom(32'hc0f47877);
      repeat (12) @(posedge CLK);
      SRST <= 1'b0;
      foreach (ra[i]) rchk(ra[i], {16'h0, rv[i]}, "reset value");
      apb(1'b0, 8'h1c, 32'h0);
      check("unmapped read", rd, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, OFS_STATE, 32'hffff);
      check("read-only write", {31'h0, err}, 32'h1);
      rchk(OFS_STATE, 32'h0, "read-only value");
      repeat (4) begin
         foreach (wa[i]) begin
            w = $urandom();
            apb(1'b1, wa[i], w);
            rchk(wa[i], w & {16'h0, wm[i]}, "readback");
         end
      end
      for (int it = 0; it < 8; it++) begin
         per = 13'($urandom_range(3));
         lin = (it == 0 || it == 2) ? 8'hff : 8'($urandom());
         pol <= 1'($urandom());
         ac = 1'($urandom());
         sm = (it == 2);
         keys <= 16'($urandom()) | (sm ? 16'h8000 : 16'h0);
         apb(1'b1, OFS_CONTROL0, 32'h1);
         apb(1'b1, OFS_IRQ_CLEAR, 32'hffff);
         apb(1'b1, OFS_LINE_ENA, {24'h0, lin});
         apb(1'b1, OFS_DRIVE_PER, {19'h0, per});
         apb(1'b1, OFS_CONTROL0, {26'h0, 1'b1, pol, sm, 1'b0, ac, 1'b0});
         repeat (8 * per + 16) @(posedge CLK);
         e1 = expv(keys, lin);
         keys <= 16'($urandom());
         repeat (8 * per + 16) @(posedge CLK);
         e2 = expv(keys, lin);
         apb(1'b1, OFS_CONTROL0, {26'h0, 1'b0, pol, sm, 1'b0, ac, 1'b0});
         rchk(OFS_STATE, {16'h0, e2}, "key vector");
         rchk(OFS_STATE, ac ? 32'h0 : {16'h0, e2}, "vector reread");
         p = sm ? first_row(e1) : e1 | e2;
         rchk(OFS_IRQ_CLEAR, {16'h0, p}, "pending");
         m = (it == 0) ? 16'h0 : 16'($urandom());
         apb(1'b1, OFS_IRQ_MASK, {16'h0, m});
         rchk(OFS_IRQ_SOURCE, {16'h0, p & ~m}, "source");
         check("irq", {31'h0, IRQ}, {31'h0, |(p & ~m)});
         c = (it == 1) ? 16'hffff : 16'($urandom());
         apb(1'b1, OFS_IRQ_CLEAR, {16'h0, c});
         rchk(OFS_IRQ_CLEAR, {16'h0, p & ~c}, "pending cleared");
         check("irq cleared", {31'h0, IRQ}, {31'h0, |(p & ~c & ~m)});
      end
      close_out();
   end
endmodule
